// [core/ctbd_pkg.sv]
package ctbd_pkg;

   // Register selector codes
   localparam logic [2:0] REG_B   = 3'h0;
   localparam logic [2:0] REG_C   = 3'h1;
   localparam logic [2:0] REG_D   = 3'h2;
   localparam logic [2:0] REG_E   = 3'h3;
   localparam logic [2:0] REG_H   = 3'h4;
   localparam logic [2:0] REG_L   = 3'h5;
   localparam logic [2:0] REG_MEM = 3'h6;
   localparam logic [2:0] REG_A   = 3'h7;

   // Pair codes
   localparam logic [1:0] PAIR_BC = 2'h0;
   localparam logic [1:0] PAIR_DE = 2'h1;
   localparam logic [1:0] PAIR_HL = 2'h2;
   localparam logic [1:0] PAIR_X  = 2'h3;

   // Condition codes
   localparam logic [2:0] CC_NZ = 3'h0;
   localparam logic [2:0] CC_Z  = 3'h1;
   localparam logic [2:0] CC_NC = 3'h2;
   localparam logic [2:0] CC_C  = 3'h3;
   localparam logic [2:0] CC_PO = 3'h4;
   localparam logic [2:0] CC_PE = 3'h5;
   localparam logic [2:0] CC_P  = 3'h6;
   localparam logic [2:0] CC_M  = 3'h7;

   // Flag byte bit positions
   localparam int FLAG_S  = 7;
   localparam int FLAG_Z  = 6;
   localparam int FLAG_P  = 2;
   localparam int FLAG_CY = 0;

   // Fixed opcodes
   localparam logic [7:0] OP_LD_IMM_MEM   = 8'h36;
   localparam logic [7:0] OP_LD_SP_IMM    = 8'h31;
   localparam logic [7:0] OP_SWAP_DE_HL   = 8'hEB;
   localparam logic [7:0] OP_PUSH_AF      = 8'hF5;
   localparam logic [7:0] OP_POP_AF       = 8'hF1;
   localparam logic [7:0] OP_SWAP_STK_HL  = 8'hE3;
   localparam logic [7:0] OP_HL_TO_SP     = 8'hF9;
   localparam logic [7:0] OP_HL_TO_PC     = 8'hE9;
   localparam logic [7:0] OP_BRANCH       = 8'hC3;
   localparam logic [7:0] OP_CALL         = 8'hCD;
   localparam logic [7:0] OP_ST_ACC_DIR   = 8'h32;
   localparam logic [7:0] OP_LD_ACC_DIR   = 8'h3A;
   localparam logic [7:0] OP_ST_PAIR_DIR  = 8'h22;
   localparam logic [7:0] OP_LD_PAIR_DIR  = 8'h2A;

   // Cycle counts
   localparam logic [4:0] CYC_4  = 5'h04;
   localparam logic [4:0] CYC_6  = 5'h06;
   localparam logic [4:0] CYC_7  = 5'h07;
   localparam logic [4:0] CYC_9  = 5'h09;
   localparam logic [4:0] CYC_10 = 5'h0A;
   localparam logic [4:0] CYC_12 = 5'h0C;
   localparam logic [4:0] CYC_13 = 5'h0D;
   localparam logic [4:0] CYC_16 = 5'h10;
   localparam logic [4:0] CYC_18 = 5'h12;
   localparam logic [4:0] CYC_NONE = 5'h00;

   typedef enum logic [4:0] {
      OPC_NONE,
      OPC_COPY_BYTE,
      OPC_STORE_REG_MEM,
      OPC_LOAD_REG_MEM,
      OPC_LOAD_IMM_BYTE,
      OPC_LOAD_IMM_MEM,
      OPC_LOAD_IMM_PAIR,
      OPC_LOAD_IMM_SP,
      OPC_STORE_ACC_IND,
      OPC_LOAD_ACC_IND,
      OPC_STORE_ACC_DIR,
      OPC_LOAD_ACC_DIR,
      OPC_STORE_PAIR_DIR,
      OPC_LOAD_PAIR_DIR,
      OPC_SWAP_DE_HL,
      OPC_PUSH_PAIR,
      OPC_PUSH_AF,
      OPC_POP_PAIR,
      OPC_POP_AF,
      OPC_SWAP_STK_HL,
      OPC_HL_TO_SP,
      OPC_HL_TO_PC,
      OPC_BRANCH,
      OPC_BRANCH_COND,
      OPC_CALL,
      OPC_CALL_COND
   } ctbd_op_t;

   typedef struct packed {
      ctbd_op_t   op;
      logic [2:0] dst;
      logic [2:0] src;
      logic [1:0] pair;
      logic       cond_taken;
      logic [4:0] cycles;
   } ctbd_dec_t;

endpackage

// [core/ctbd_cond_eval.sv]
module ctbd_cond_eval
   import ctbd_pkg::*;
(
   input  wire logic [2:0] cc,
   input  wire logic [7:0] flags,
   output logic            taken
);

   always_comb
   begin
      case (cc)
         CC_NZ:   taken = !flags[FLAG_Z];
         CC_Z:    taken = flags[FLAG_Z];
         CC_NC:   taken = !flags[FLAG_CY];
         CC_C:    taken = flags[FLAG_CY];
         CC_PO:   taken = !flags[FLAG_P];
         CC_PE:   taken = flags[FLAG_P];
         CC_P:    taken = !flags[FLAG_S];
         CC_M:    taken = flags[FLAG_S];
         default: taken = 1'b0;
      endcase
   end

endmodule // ctbd_cond_eval

// [core/ctbd_decoder.sv]
// Overview of operation
// (RULE1) 01dddsss copies register, 4 cycles
// (RULE2) 01110sss stores register to memory, 7
// (RULE3) 01ddd110 loads register from memory, 7
// (RULE4) 00ddd110 loads immediate byte, 7 cycles
// (RULE5) 00110110 immediate to memory, 10 cycles
// (RULE6) 00pp0001 loads immediate pair, 10 cycles
// (RULE7) 00110001 loads stack pointer, 10 cycles
// (RULE8) 11101011 swaps DE with HL, 4
// (RULE9) 11pp0101 pushes pair, 12 cycles
// (RULE10) 11110101 pushes accumulator and flags, 12
// (RULE11) 11pp0001 pops pair, 10 cycles
// (RULE12) 11110001 pops accumulator and flags, 10
// (RULE13) 11100011 swaps HL with stack top, 16
// (RULE14) 11111001 copies HL to stack pointer, 6
// (RULE15) 11101001 jumps through HL, 6 cycles
// (RULE16) Register codes B..L, memory 110, A 111
// (RULE17) Conditional: short if fails, long if holds
// (RULE18) Branch 10; conditional branch 7 or 10
// (RULE19) Call 18; conditional call 9 or 18
// (RULE20) Accumulator indirect 7, direct 13, pair 16
module ctbd_decoder
   import ctbd_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            op_valid,
   input  wire logic [7:0]      opcode,
   input  wire logic [7:0]      flags,
   output ctbd_pkg::ctbd_dec_t  dec_q,
   output logic                 dec_valid_q,
   output logic                 busy,
   output logic                 done
);
   import ctbd_pkg::*;

   ////////////////////////////////////////////////////////////////////
   ctbd_dec_t  dec_d;
   logic       cond_ok;
   logic [4:0] cnt_q;

   // Field extraction used in several places
   function automatic logic [2:0] dst_of(input logic [7:0] o);
      return o[5:3];
   endfunction

   function automatic logic [2:0] src_of(input logic [7:0] o);
      return o[2:0];
   endfunction

   ctbd_cond_eval u_cond (
      .cc    (dst_of(opcode)),
      .flags (flags),
      .taken (cond_ok)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      dec_d            = '0;
      dec_d.op         = OPC_NONE;
      dec_d.dst        = dst_of(opcode);  // [RULE16]
      dec_d.src        = src_of(opcode);  // [RULE16]
      dec_d.pair       = opcode[5:4];
      dec_d.cond_taken = 1'b1;
      dec_d.cycles     = CYC_NONE;
      // Fixed opcodes first; they overlap the field patterns below
      case (opcode)
         OP_LD_IMM_MEM:  begin dec_d.op = OPC_LOAD_IMM_MEM;   dec_d.cycles = CYC_10; end // [RULE5]
         OP_LD_SP_IMM:   begin dec_d.op = OPC_LOAD_IMM_SP;    dec_d.cycles = CYC_10; end // [RULE7]
         OP_SWAP_DE_HL:  begin dec_d.op = OPC_SWAP_DE_HL;     dec_d.cycles = CYC_4;  end // [RULE8]
         OP_PUSH_AF:     begin dec_d.op = OPC_PUSH_AF;        dec_d.cycles = CYC_12; end // [RULE10]
         OP_POP_AF:      begin dec_d.op = OPC_POP_AF;         dec_d.cycles = CYC_10; end // [RULE12]
         OP_SWAP_STK_HL: begin dec_d.op = OPC_SWAP_STK_HL;    dec_d.cycles = CYC_16; end // [RULE13]
         OP_HL_TO_SP:    begin dec_d.op = OPC_HL_TO_SP;       dec_d.cycles = CYC_6;  end // [RULE14]
         OP_HL_TO_PC:    begin dec_d.op = OPC_HL_TO_PC;       dec_d.cycles = CYC_6;  end // [RULE15]
         OP_BRANCH:      begin dec_d.op = OPC_BRANCH;         dec_d.cycles = CYC_10; end // [RULE18]
         OP_CALL:        begin dec_d.op = OPC_CALL;           dec_d.cycles = CYC_18; end // [RULE19]
         OP_ST_ACC_DIR:  begin dec_d.op = OPC_STORE_ACC_DIR;  dec_d.cycles = CYC_13; end // [RULE20]
         OP_LD_ACC_DIR:  begin dec_d.op = OPC_LOAD_ACC_DIR;   dec_d.cycles = CYC_13; end // [RULE20]
         OP_ST_PAIR_DIR: begin dec_d.op = OPC_STORE_PAIR_DIR; dec_d.cycles = CYC_16; end // [RULE20]
         OP_LD_PAIR_DIR: begin dec_d.op = OPC_LOAD_PAIR_DIR;  dec_d.cycles = CYC_16; end // [RULE20]
         default:
         begin
            if (opcode[7:6] == 2'b01)
            begin
               // 0x76 is halt, outside this block
               if (dst_of(opcode) == REG_MEM && src_of(opcode) == REG_MEM)
               begin
                  dec_d.op = OPC_NONE;
               end
               else if (dst_of(opcode) == REG_MEM)
               begin
                  dec_d.op     = OPC_STORE_REG_MEM;  // [RULE2]
                  dec_d.cycles = CYC_7;
               end
               else if (src_of(opcode) == REG_MEM)
               begin
                  dec_d.op     = OPC_LOAD_REG_MEM;  // [RULE3]
                  dec_d.cycles = CYC_7;
               end
               else
               begin
                  dec_d.op     = OPC_COPY_BYTE;  // [RULE1]
                  dec_d.cycles = CYC_4;
               end
            end
            else if (opcode[7:6] == 2'b00 && src_of(opcode) == 3'h6)
            begin
               dec_d.op     = OPC_LOAD_IMM_BYTE;  // [RULE4]
               dec_d.cycles = CYC_7;
            end
            else if (opcode[7:6] == 2'b00 && opcode[3:0] == 4'h1)
            begin
               dec_d.op     = OPC_LOAD_IMM_PAIR;  // [RULE6]
               dec_d.cycles = CYC_10;
            end
            else if (opcode[7:5] == 3'b000 && opcode[3:0] == 4'h2)
            begin
               dec_d.op     = OPC_STORE_ACC_IND;  // [RULE20]
               dec_d.pair   = {1'b0, opcode[4]};
               dec_d.cycles = CYC_7;
            end
            else if (opcode[7:5] == 3'b000 && opcode[3:0] == 4'hA)
            begin
               dec_d.op     = OPC_LOAD_ACC_IND;  // [RULE20]
               dec_d.pair   = {1'b0, opcode[4]};
               dec_d.cycles = CYC_7;
            end
            else if (opcode[7:6] == 2'b11 && opcode[3:0] == 4'h5
                     && opcode[5:4] != PAIR_X)
            begin
               dec_d.op     = OPC_PUSH_PAIR;  // [RULE9]
               dec_d.cycles = CYC_12;
            end
            else if (opcode[7:6] == 2'b11 && opcode[3:0] == 4'h1
                     && opcode[5:4] != PAIR_X)
            begin
               dec_d.op     = OPC_POP_PAIR;  // [RULE11]
               dec_d.cycles = CYC_10;
            end
            else if (opcode[7:6] == 2'b11 && src_of(opcode) == 3'h2)
            begin
               dec_d.op         = OPC_BRANCH_COND;  // [RULE18]
               dec_d.cond_taken = cond_ok;
               dec_d.cycles     = cond_ok ? CYC_10 : CYC_7;  // [RULE17]
            end
            else if (opcode[7:6] == 2'b11 && src_of(opcode) == 3'h4)
            begin
               dec_d.op         = OPC_CALL_COND;  // [RULE19]
               dec_d.cond_taken = cond_ok;
               dec_d.cycles     = cond_ok ? CYC_18 : CYC_9;  // [RULE17]
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Latch decode; new opcodes ignored while busy, accepted again in the done cycle
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         dec_q       <= '0;
         dec_valid_q <= 1'b0;
      end
      else if (op_valid && !busy)
      begin
         dec_q       <= dec_d;
         dec_valid_q <= (dec_d.op != OPC_NONE);
      end
      else if (done)
      begin
         dec_valid_q <= 1'b0;
      end
   end

   // Cycle counter, loaded at accept, counts down to 0; done at 1
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= '0;
      end
      else if (op_valid && !busy)
      begin
         cnt_q <= dec_d.cycles;
      end
      else if (cnt_q != '0)
      begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   assign busy = (cnt_q > 5'h01);
   assign done = (cnt_q == 5'h01);

   ////////////////////////////////////////////////////////////////////
   sequence s_accept;
      op_valid && !busy;
   endsequence

   AST_COPY_4: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE1]
      s_accept and opcode == 8'h41 |=> dec_q.op == OPC_COPY_BYTE && cnt_q == CYC_4)
      else $error("copy cycles wrong");

   AST_STORE_MEM: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE2]
      s_accept and opcode == 8'h77 |=> dec_q.op == OPC_STORE_REG_MEM && cnt_q == CYC_7)
      else $error("store reg to memory wrong");

   AST_LOAD_MEM: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE3]
      s_accept and opcode == 8'h7E |=> dec_q.op == OPC_LOAD_REG_MEM && dec_q.dst == REG_A)
      else $error("load reg from memory wrong");

   AST_IMM_MEM: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE5]
      s_accept and opcode == OP_LD_IMM_MEM |=> cnt_q == CYC_10 ##9 done)
      else $error("immediate to memory timing wrong");

   // Repeat kept short; the count check pins the start of the run
   AST_PUSH_12: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE9]
      s_accept and opcode[7:6] == 2'b11 and opcode[3:0] == 4'h5
      |=> cnt_q == CYC_12 ##1 busy [*8] ##3 done)
      else $error("push timing wrong");

   AST_SWAP_STK: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE13]
      s_accept and opcode == OP_SWAP_STK_HL |=> ##15 done)
      else $error("stack swap timing wrong");

   AST_COND_JMP: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE17]
      s_accept and opcode[7:6] == 2'b11 and opcode[2:0] == 3'h2
      |=> cnt_q == (dec_q.cond_taken ? CYC_10 : CYC_7))
      else $error("conditional branch count wrong");

   AST_COND_CALL: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE19]
      s_accept and opcode[7:6] == 2'b11 and opcode[2:0] == 3'h4
      |=> cnt_q == (dec_q.cond_taken ? CYC_18 : CYC_9))
      else $error("conditional call count wrong");

   AST_HOLD_BUSY: assert property (@(posedge clk_sys) disable iff (rst)
      busy |=> $stable(dec_q))
      else $error("decode changed while busy");

   AST_IMM_BYTE: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE4]
      s_accept and opcode == 8'h3E
      |=> dec_q.op == OPC_LOAD_IMM_BYTE && dec_q.dst == REG_A && cnt_q == CYC_7)
      else $error("immediate byte load wrong");

   AST_IMM_PAIR: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE6]
      s_accept and opcode == 8'h21
      |=> dec_q.op == OPC_LOAD_IMM_PAIR && dec_q.pair == PAIR_HL && cnt_q == CYC_10)
      else $error("immediate pair load wrong");

   AST_IMM_SP: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE7]
      s_accept and opcode == OP_LD_SP_IMM |=> dec_q.op == OPC_LOAD_IMM_SP ##9 done)
      else $error("stack pointer load wrong");

   AST_SWAP_DE: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE8]
      s_accept and opcode == OP_SWAP_DE_HL |=> busy ##3 done)
      else $error("pair swap timing wrong");

   AST_PUSH_AF: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE10]
      s_accept and opcode == OP_PUSH_AF |=> dec_q.op == OPC_PUSH_AF && cnt_q == CYC_12)
      else $error("accumulator push wrong");

   AST_POP_PAIR: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE11]
      s_accept and opcode == 8'hD1
      |=> dec_q.op == OPC_POP_PAIR && dec_q.pair == PAIR_DE ##9 done)
      else $error("pair pop wrong");

   AST_POP_AF: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE12]
      s_accept and opcode == OP_POP_AF |=> dec_q.op == OPC_POP_AF && cnt_q == CYC_10)
      else $error("accumulator pop wrong");

   AST_HL_SP: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE14]
      s_accept and opcode == OP_HL_TO_SP |=> dec_q.op == OPC_HL_TO_SP ##5 done)
      else $error("pair to stack pointer wrong");

   AST_HL_PC: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE15]
      s_accept and opcode == OP_HL_TO_PC |=> dec_q.op == OPC_HL_TO_PC ##5 done)
      else $error("pair to program counter wrong");

   AST_REG_CODE: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE16]
      s_accept and opcode == 8'h78 |=> dec_q.dst == REG_A && dec_q.src == REG_B)
      else $error("register code wrong");

   AST_BRANCH: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE18]
      s_accept and opcode == OP_BRANCH |=> dec_q.op == OPC_BRANCH ##9 done)
      else $error("branch timing wrong");

   AST_CALL: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE19]
      s_accept and opcode == OP_CALL |=> cnt_q == CYC_18 ##17 done)
      else $error("call timing wrong");

   AST_ACC_DIR: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE20]
      s_accept and opcode == OP_ST_ACC_DIR |=> cnt_q == CYC_13 ##12 done)
      else $error("direct accumulator store wrong");

   AST_ACC_IND: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE20]
      s_accept and opcode == 8'h1A
      |=> dec_q.op == OPC_LOAD_ACC_IND && dec_q.pair == PAIR_DE && cnt_q == CYC_7)
      else $error("indirect accumulator load wrong");

   // Zero test checked against the flag pin itself, not the evaluator
   AST_JZ_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE17]
      s_accept and opcode == 8'hCA and flags[FLAG_Z]
      |=> dec_q.cond_taken && cnt_q == CYC_10)
      else $error("taken branch count wrong");

   AST_JZ_SKIP: assert property (@(posedge clk_sys) disable iff (rst)  // [RULE17]
      s_accept and opcode == 8'hCA and !flags[FLAG_Z]
      |=> !dec_q.cond_taken && cnt_q == CYC_7)
      else $error("skipped branch count wrong");

   AST_REFUSE_HALT: assert property (@(posedge clk_sys) disable iff (rst)
      s_accept and opcode == 8'h76 |=> !dec_valid_q && !busy && !done)
      else $error("foreign opcode not refused");

endmodule // ctbd_decoder

// [tb/tb_ctbd.sv]
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ctbd_pkg::*;

   logic             clk_sys;
   logic             rst;
   logic             op_valid;
   logic [7:0]       opcode;
   logic [7:0]       flags;
   ctbd_dec_t        dec_q;
   logic             dec_valid_q;
   logic             busy;
   logic             done;
   int               err_total;
   int               checked;

   ctbd_decoder ctbd_decoder_inst (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid),
      .opcode(opcode), .flags(flags), .dec_q(dec_q), .dec_valid_q(dec_valid_q),
      .busy(busy), .done(done));

   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
   begin
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   end
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
   begin
      checked++;
      if (exp !== got)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   end
   endtask

   // Counts cycles from accept to the done pulse; a hang is cut at 40
   task automatic wait_done(output int k);
   begin
      k = 1;
      while (done !== 1'b1 && k < 40)
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      if (k >= 40)
      begin
         $display("MISMATCH done expected 1 seen 0");
         err_total++;
         test_done();
      end
   end
   endtask

   // Offer one opcode, check the decode and the instruction length
   task automatic issue(input logic [7:0] opc, input logic [7:0] flg, input ctbd_op_t eop,
                        input logic [4:0] ecyc, input logic [2:0] edst, input logic [2:0] esrc,
                        input logic [1:0] epair, input logic ecnd, input logic [3:0] sel);
      int k;
   begin
      opcode = opc;
      flags = flg;
      op_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      op_valid = 1'b0;
      chk("op", 8'(eop), 8'(dec_q.op));
      chk("cycles", 8'(ecyc), 8'(dec_q.cycles));
      chk("valid", 8'h01, 8'(dec_valid_q));
      chk("busy", 8'(ecyc > 5'h01), 8'(busy));
      if (sel[3]) chk("dst", 8'(edst), 8'(dec_q.dst));
      if (sel[2]) chk("src", 8'(esrc), 8'(dec_q.src));
      if (sel[1]) chk("pair", 8'(epair), 8'(dec_q.pair));
      if (sel[0]) chk("cond", 8'(ecnd), 8'(dec_q.cond_taken));
      wait_done(k);
      chk("length", 8'(ecyc), 8'(k));
      chk("busy_end", 8'h00, 8'(busy));
   end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_copy();
      logic [7:0] o;
   begin
      for (int i = 0; i < 64; i++)
      begin
         o = 8'h40 + 8'(i);
         if (o == 8'h76) continue;
         if (o[5:3] == REG_MEM)
            issue(o, 8'h00, OPC_STORE_REG_MEM, CYC_7, 0, o[2:0], 0, 0, 4'h4);
         else if (o[2:0] == REG_MEM)
            issue(o, 8'h00, OPC_LOAD_REG_MEM, CYC_7, o[5:3], 0, 0, 0, 4'h8);
         else
            issue(o, 8'h00, OPC_COPY_BYTE, CYC_4, o[5:3], o[2:0], 0, 0, 4'hC);
      end
      $display("test_copy finished");
   end
   endtask

   task automatic test_load();
      logic [7:0] o;
   begin
      for (int d = 0; d < 8; d++)
      begin
         o = {2'b00, 3'(d), 3'b110};
         if (d == 6)
            issue(o, 8'h00, OPC_LOAD_IMM_MEM, CYC_10, 0, 0, 0, 0, 4'h0);
         else
            issue(o, 8'h00, OPC_LOAD_IMM_BYTE, CYC_7, 3'(d), 0, 0, 0, 4'h8);
      end
      for (int p = 0; p < 3; p++)
         issue({2'b00, 2'(p), 4'h1}, 0, OPC_LOAD_IMM_PAIR, CYC_10, 0, 0, 2'(p), 0, 4'h2);
      issue(OP_LD_SP_IMM, 8'h00, OPC_LOAD_IMM_SP, CYC_10, 0, 0, 0, 0, 4'h0);
      for (int p = 0; p < 2; p++)
      begin
         issue({3'b000, 1'(p), 4'h2}, 0, OPC_STORE_ACC_IND, CYC_7, 0, 0, 2'(p), 0, 4'h2);
         issue({3'b000, 1'(p), 4'hA}, 0, OPC_LOAD_ACC_IND, CYC_7, 0, 0, 2'(p), 0, 4'h2);
      end
      issue(OP_ST_ACC_DIR, 8'h00, OPC_STORE_ACC_DIR, CYC_13, 0, 0, 0, 0, 4'h0);
      issue(OP_LD_ACC_DIR, 8'h00, OPC_LOAD_ACC_DIR, CYC_13, 0, 0, 0, 0, 4'h0);
      issue(OP_ST_PAIR_DIR, 8'h00, OPC_STORE_PAIR_DIR, CYC_16, 0, 0, 0, 0, 4'h0);
      issue(OP_LD_PAIR_DIR, 8'h00, OPC_LOAD_PAIR_DIR, CYC_16, 0, 0, 0, 0, 4'h0);
      $display("test_load finished");
   end
   endtask

   task automatic test_stack();
   begin
      for (int p = 0; p < 3; p++)
      begin
         issue({2'b11, 2'(p), 4'h5}, 0, OPC_PUSH_PAIR, CYC_12, 0, 0, 2'(p), 0, 4'h2);
         issue({2'b11, 2'(p), 4'h1}, 0, OPC_POP_PAIR, CYC_10, 0, 0, 2'(p), 0, 4'h2);
      end
      issue(OP_PUSH_AF, 8'h00, OPC_PUSH_AF, CYC_12, 0, 0, 0, 0, 4'h0);
      issue(OP_POP_AF, 8'h00, OPC_POP_AF, CYC_10, 0, 0, 0, 0, 4'h0);
      issue(OP_SWAP_STK_HL, 8'h00, OPC_SWAP_STK_HL, CYC_16, 0, 0, 0, 0, 4'h0);
      issue(OP_HL_TO_SP, 8'h00, OPC_HL_TO_SP, CYC_6, 0, 0, 0, 0, 4'h0);
      issue(OP_SWAP_DE_HL, 8'h00, OPC_SWAP_DE_HL, CYC_4, 0, 0, 0, 0, 4'h0);
      issue(OP_HL_TO_PC, 8'h00, OPC_HL_TO_PC, CYC_6, 0, 0, 0, 0, 4'h0);
      $display("test_stack finished");
   end
   endtask

   // One-hot flag bytes show that each condition looks at its own flag only
   task automatic test_branch();
      logic [7:0] fl;
      int         pos;
      logic       tk;
   begin
      issue(OP_BRANCH, 8'h00, OPC_BRANCH, CYC_10, 0, 0, 0, 0, 4'h0);
      issue(OP_CALL, 8'h00, OPC_CALL, CYC_18, 0, 0, 0, 0, 4'h0);
      for (int c = 0; c < 8; c++)
      begin
         pos = (c / 2 == 0) ? FLAG_Z : (c / 2 == 1) ? FLAG_CY : (c / 2 == 2) ? FLAG_P : FLAG_S;
         for (int f = 0; f < 4; f++)
         begin
            fl = (f == 0) ? 8'h80 : (f == 1) ? 8'h40 : (f == 2) ? 8'h04 : 8'h01;
            tk = (c % 2 == 1) ? fl[pos] : !fl[pos];
            issue({2'b11, 3'(c), 3'b010}, fl, OPC_BRANCH_COND, tk ? CYC_10 : CYC_7,
                  0, 0, 0, tk, 4'h1);
            issue({2'b11, 3'(c), 3'b100}, fl, OPC_CALL_COND, tk ? CYC_18 : CYC_9,
                  0, 0, 0, tk, 4'h1);
         end
      end
      $display("test_branch finished");
   end
   endtask

   // Foreign opcodes give nothing; a request held while busy waits for done
   task automatic test_refuse();
      logic [7:0] bad [3] = '{8'h76, 8'h00, 8'hC9};
      int         k;
   begin
      // Valid stays up across the foreign opcodes and into the branch
      foreach (bad[i])
      begin
         opcode = bad[i];
         op_valid = 1'b1;
         @(posedge clk_sys);
         #1;
         chk("bad_valid", 8'h00, {6'h00, busy, dec_valid_q});
         chk("bad_done", 8'h00, {3'h0, dec_q.cycles} | 8'(done));
      end
      opcode = OP_BRANCH;
      @(posedge clk_sys);
      #1;
      opcode = OP_SWAP_DE_HL;
      wait_done(k);
      chk("held_len", 8'(CYC_10), 8'(k));
      chk("held_op", 8'(OPC_BRANCH), 8'(dec_q.op));
      @(posedge clk_sys);
      #1;
      op_valid = 1'b0;
      chk("next_op", 8'(OPC_SWAP_DE_HL), 8'(dec_q.op));
      wait_done(k);
      chk("next_len", 8'(CYC_4), 8'(k));
      @(posedge clk_sys);
      #1;
      chk("valid_drop", 8'h00, 8'(dec_valid_q));
      $display("test_refuse finished");
   end
   endtask

   task automatic test_reset();
   begin
      opcode = OP_CALL;
      op_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      op_valid = 1'b0;
      rst = 1'b1;
      #1;
      chk("rst_out", 8'h00, {5'h00, busy, done, dec_valid_q});
      @(posedge clk_sys);
      #1;
      rst = 1'b0;
      issue(OP_HL_TO_SP, 8'h00, OPC_HL_TO_SP, CYC_6, 0, 0, 0, 0, 4'h0);
      $display("test_reset finished");
   end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      err_total = 0;
      checked = 0;
      rst = 1'b1;
      op_valid = 1'b0;
      opcode = 8'h00;
      flags = 8'h00;
      repeat (16) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      test_copy();
      test_load();
      test_stack();
      test_branch();
      test_refuse();
      test_reset();
      test_done();
   end
endmodule // tb
